/* File: verilog/twi_pkg.sv */
package twi_pkg;

    // ==========================================
    // Register map (word aligned, byte offsets)
    localparam logic [7:0] ADDR_WAKE_EN       = 8'h00;
    localparam logic [7:0] ADDR_WAKE_EDGE     = 8'h04;
    localparam logic [7:0] ADDR_WAKE_PEND     = 8'h08;
    localparam logic [7:0] ADDR_CTRL          = 8'h0c;
    localparam logic [7:0] ADDR_STATUS        = 8'h10;

    // ==========================================
    // Control and status fields
    localparam int CTRL_GIE_BIT    = 0;
    localparam int CTRL_GROUP_BIT  = 1;
    localparam int STAT_TRAP_BIT   = 0;
    localparam int STAT_BOOT_BIT   = 1;
    localparam int STAT_INSVC_BIT  = 2;
    localparam int STAT_WAKEIRQ_BIT = 3;

    // ==========================================
    // Reset values
    localparam logic [7:0] RST_WAKE_EN   = 8'h00;
    localparam logic [7:0] RST_WAKE_EDGE = 8'h00;
    localparam logic [7:0] RST_WAKE_PEND = 8'h00;
    localparam logic [1:0] RST_CTRL      = 2'h0;

    // ==========================================
    // Opcodes, vectors, stack limits
    localparam logic [7:0]  OPC_TRAP       = 8'h00;
    localparam logic [7:0]  VEC_TRAP       = 8'hfe;
    localparam logic [7:0]  VEC_DEFAULT    = 8'he0;
    localparam logic [7:0]  VEC_WAKE       = 8'he2;
    localparam logic [7:0]  STACK_LIMIT    = 8'h6f;
    localparam logic [14:0] PC_OVERPOP     = 15'h7fff;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : twi_pkg

/* File: verilog/twi_irq_ctrl.sv */
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

module twi_irq_ctrl #(
    parameter int PINS = 8
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // AXI4-Lite slave
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Core side
    input  wire logic              ir_load_i,
    input  wire logic [7:0]        ir_opcode_i,
    input  wire logic [14:0]       ir_pc_i,
    input  wire logic              clear_trap_pending_instr_i,
    input  wire logic              vector_select_instr_i,
    input  wire logic              return_from_irq_instr_i,
    input  wire logic              stack_pop_i,
    input  wire logic [7:0]        stack_ptr_i,
    input  wire logic              boot_rom_exec_i,
    input  wire logic              halt_idle_i,
    input  wire logic [PINS-1:0]   wake_pin_i,
    output logic                   trap_take_o,
    output logic [14:0]            trap_push_addr_o,
    output logic                   pc_overpop_o,
    output logic [14:0]            pc_overpop_val_o,
    output logic                   wake_irq_o,
    output logic                   irq_take_o,
    output logic                   wake_resume_o,
    output logic [7:0]             vector_low_o,
    output logic                   in_service_o
);

    // ==========================================
    // State
    logic [PINS-1:0] wake_pin_enable_reg_r, wake_pin_enable_reg_nxt;
    logic [PINS-1:0] wake_edge_polarity_reg_r, wake_edge_polarity_reg_nxt;
    logic [PINS-1:0] wake_pin_pending_reg_r, wake_pin_pending_reg_nxt;
    logic [PINS-1:0] pin_prev_r, pin_prev_nxt;
    logic            global_irq_enable_r, global_irq_enable_nxt;
    logic            wake_port_group_enable_r, wake_port_group_enable_nxt;
    logic            trap_pending_flag_r, trap_pending_flag_nxt;
    logic            in_service_r, in_service_nxt;
    logic            overpop_r, overpop_nxt;
    logic [7:0]      vector_r, vector_nxt;
    logic            trap_take_r, trap_take_nxt;
    logic [14:0]     push_r, push_nxt;
    logic            irq_take_r, irq_take_nxt;
    logic            resume_r, resume_nxt;

    // Bus state
    logic            aw_have_r, aw_have_nxt;
    logic            w_have_r, w_have_nxt;
    logic [7:0]      aw_addr_r, aw_addr_nxt;
    logic [31:0]     w_data_r, w_data_nxt;
    logic            bvalid_r, bvalid_nxt;
    logic [1:0]      bresp_r, bresp_nxt;
    logic            rvalid_r, rvalid_nxt;
    logic [31:0]     rdata_r, rdata_nxt;
    logic [1:0]      rresp_r, rresp_nxt;

    logic [PINS-1:0] edge_hit;
    logic            trap_event;
    logic            wake_req;
    logic            do_write;
    logic            do_read;

    // ==========================================
    // Trap detection
    // Fetch of zero (also unprogrammed or overpopped memory) is the trap opcode
    assign trap_event = ir_load_i && (ir_opcode_i == twi_pkg::OPC_TRAP);

    // ==========================================
    // Wake edge detection
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_edge
            // Polarity 1 selects falling edge, 0 rising
            assign edge_hit[g] = wake_edge_polarity_reg_r[g]
                               ? (pin_prev_r[g] && !wake_pin_i[g])
                               : (!pin_prev_r[g] && wake_pin_i[g]);
        end
    endgenerate

    assign wake_req = |(wake_pin_pending_reg_r & wake_pin_enable_reg_r)
                    && wake_port_group_enable_r && global_irq_enable_r;

    // ==========================================
    // Bus decode
    assign do_write = aw_have_r && w_have_r && !bvalid_r;
    assign do_read  = s_axi_arvalid && !rvalid_r;

    // ==========================================
    // Interrupt state next values
    always_comb begin
        wake_pin_enable_reg_nxt    = wake_pin_enable_reg_r;
        wake_edge_polarity_reg_nxt = wake_edge_polarity_reg_r;
        wake_pin_pending_reg_nxt   = wake_pin_pending_reg_r;
        global_irq_enable_nxt      = global_irq_enable_r;
        wake_port_group_enable_nxt = wake_port_group_enable_r;
        trap_pending_flag_nxt      = trap_pending_flag_r;
        in_service_nxt             = in_service_r;
        pin_prev_nxt               = wake_pin_i;
        overpop_nxt                = 1'b0;
        vector_nxt                 = vector_r;
        trap_take_nxt              = 1'b0;
        push_nxt                   = push_r;
        irq_take_nxt               = 1'b0;
        resume_nxt                 = 1'b0;

        // Software writes first so hardware events win
        if (do_write) begin
            unique case (aw_addr_r)
                twi_pkg::ADDR_WAKE_EN:   wake_pin_enable_reg_nxt = w_data_r[PINS-1:0];
                twi_pkg::ADDR_WAKE_EDGE: wake_edge_polarity_reg_nxt = w_data_r[PINS-1:0];
                // Write one to clear
                twi_pkg::ADDR_WAKE_PEND:
                    wake_pin_pending_reg_nxt = wake_pin_pending_reg_r & ~w_data_r[PINS-1:0];
                twi_pkg::ADDR_CTRL: begin
                    global_irq_enable_nxt      = w_data_r[twi_pkg::CTRL_GIE_BIT];
                    wake_port_group_enable_nxt = w_data_r[twi_pkg::CTRL_GROUP_BIT];
                end
                default: ;
            endcase
        end

        // Edges latch; while in boot ROM an already pending bit just stays set
        wake_pin_pending_reg_nxt = wake_pin_pending_reg_nxt | edge_hit;

        if (stack_pop_i && stack_ptr_i > twi_pkg::STACK_LIMIT) begin
            overpop_nxt = 1'b1;
        end

        if (clear_trap_pending_instr_i) begin
            trap_pending_flag_nxt = 1'b0;
        end
        if (trap_event) begin
            // Immediate, ignores all enables and may preempt any routine
            trap_pending_flag_nxt = 1'b1;
            trap_take_nxt         = 1'b1;
            push_nxt              = ir_pc_i;
            in_service_nxt        = 1'b1;
        end else if (wake_req && !trap_pending_flag_r && !in_service_r
                     && !boot_rom_exec_i && !halt_idle_i) begin
            // Global enable left as is by both paths
            irq_take_nxt   = 1'b1;
            in_service_nxt = 1'b1;
        end

        if (return_from_irq_instr_i) begin
            in_service_nxt = 1'b0;
        end

        // Halt exit: with wake interrupt disabled resume next instruction
        if (halt_idle_i && |(edge_hit & wake_pin_enable_reg_r)) begin
            resume_nxt = !(wake_port_group_enable_r && global_irq_enable_r);
        end

        if (vector_select_instr_i) begin
            if (trap_pending_flag_r) begin
                vector_nxt = twi_pkg::VEC_TRAP;
            end else if (wake_req) begin
                vector_nxt = twi_pkg::VEC_WAKE;
            end else begin
                vector_nxt = twi_pkg::VEC_DEFAULT;
            end
        end
    end

    // ==========================================
    // Bus next values
    always_comb begin
        aw_have_nxt = aw_have_r;
        w_have_nxt  = w_have_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt  = w_data_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
        end
        if (do_write) begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = (aw_addr_r <= twi_pkg::ADDR_CTRL && aw_addr_r[1:0] == 2'h0)
                        ? twi_pkg::RESP_OKAY : twi_pkg::RESP_SLVERR;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (do_read) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = twi_pkg::RESP_OKAY;
            rdata_nxt  = 32'h0;
            unique case (s_axi_araddr)
                twi_pkg::ADDR_WAKE_EN:   rdata_nxt[PINS-1:0] = wake_pin_enable_reg_r;
                twi_pkg::ADDR_WAKE_EDGE: rdata_nxt[PINS-1:0] = wake_edge_polarity_reg_r;
                twi_pkg::ADDR_WAKE_PEND: rdata_nxt[PINS-1:0] = wake_pin_pending_reg_r;
                twi_pkg::ADDR_CTRL: begin
                    rdata_nxt[twi_pkg::CTRL_GIE_BIT]   = global_irq_enable_r;
                    rdata_nxt[twi_pkg::CTRL_GROUP_BIT] = wake_port_group_enable_r;
                end
                // Read-only view; the trap flag stays hidden from software
                twi_pkg::ADDR_STATUS: begin
                    rdata_nxt[twi_pkg::STAT_TRAP_BIT]    = 1'b0;
                    rdata_nxt[twi_pkg::STAT_BOOT_BIT]    = boot_rom_exec_i;
                    rdata_nxt[twi_pkg::STAT_INSVC_BIT]   = in_service_r;
                    rdata_nxt[twi_pkg::STAT_WAKEIRQ_BIT] = wake_req;
                end
                default: rresp_nxt = twi_pkg::RESP_SLVERR;
            endcase
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wake_pin_enable_reg_r    <= twi_pkg::RST_WAKE_EN;
            wake_edge_polarity_reg_r <= twi_pkg::RST_WAKE_EDGE;
            wake_pin_pending_reg_r   <= twi_pkg::RST_WAKE_PEND;
            pin_prev_r               <= wake_pin_i;
            global_irq_enable_r      <= twi_pkg::RST_CTRL[twi_pkg::CTRL_GIE_BIT];
            wake_port_group_enable_r <= twi_pkg::RST_CTRL[twi_pkg::CTRL_GROUP_BIT];
            trap_pending_flag_r      <= 1'b0;
            in_service_r             <= 1'b0;
            overpop_r                <= 1'b0;
            vector_r                 <= twi_pkg::VEC_DEFAULT;
            trap_take_r              <= 1'b0;
            push_r                   <= 15'h0;
            irq_take_r               <= 1'b0;
            resume_r                 <= 1'b0;
            aw_have_r                <= 1'b0;
            w_have_r                 <= 1'b0;
            aw_addr_r                <= 8'h0;
            w_data_r                 <= 32'h0;
            bvalid_r                 <= 1'b0;
            bresp_r                  <= 2'h0;
            rvalid_r                 <= 1'b0;
            rdata_r                  <= 32'h0;
            rresp_r                  <= 2'h0;
        end else if (ce_i) begin
            wake_pin_enable_reg_r    <= wake_pin_enable_reg_nxt;
            wake_edge_polarity_reg_r <= wake_edge_polarity_reg_nxt;
            wake_pin_pending_reg_r   <= wake_pin_pending_reg_nxt;
            pin_prev_r               <= pin_prev_nxt;
            global_irq_enable_r      <= global_irq_enable_nxt;
            wake_port_group_enable_r <= wake_port_group_enable_nxt;
            trap_pending_flag_r      <= trap_pending_flag_nxt;
            in_service_r             <= in_service_nxt;
            overpop_r                <= overpop_nxt;
            vector_r                 <= vector_nxt;
            trap_take_r              <= trap_take_nxt;
            push_r                   <= push_nxt;
            irq_take_r               <= irq_take_nxt;
            resume_r                 <= resume_nxt;
            aw_have_r                <= aw_have_nxt;
            w_have_r                 <= w_have_nxt;
            aw_addr_r                <= aw_addr_nxt;
            w_data_r                 <= w_data_nxt;
            bvalid_r                 <= bvalid_nxt;
            bresp_r                  <= bresp_nxt;
            rvalid_r                 <= rvalid_nxt;
            rdata_r                  <= rdata_nxt;
            rresp_r                  <= rresp_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign s_axi_awready    = ce_i && !aw_have_r;
    assign s_axi_wready     = ce_i && !w_have_r;
    assign s_axi_bvalid     = bvalid_r;
    assign s_axi_bresp      = bresp_r;
    assign s_axi_arready    = ce_i && !rvalid_r;
    assign s_axi_rvalid     = rvalid_r;
    assign s_axi_rdata      = rdata_r;
    assign s_axi_rresp      = rresp_r;
    assign trap_take_o      = trap_take_r;
    assign trap_push_addr_o = push_r;
    assign pc_overpop_o     = overpop_r;
    assign pc_overpop_val_o = twi_pkg::PC_OVERPOP;
    assign wake_irq_o       = wake_req;
    assign irq_take_o       = irq_take_r;
    assign wake_resume_o    = resume_r;
    assign vector_low_o     = vector_r;
    assign in_service_o     = in_service_r;

    // ==========================================
    // Assertions
    property p_trap_set;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && trap_event) |=> trap_pending_flag_r && trap_take_o;
    endproperty
    a_trap_set: assert property (p_trap_set) else $error("trap not set");

    property p_trap_clear;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && clear_trap_pending_instr_i && !trap_event) |=> !trap_pending_flag_r;
    endproperty
    a_trap_clear: assert property (p_trap_clear) else $error("trap not cleared");

    property p_trap_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && trap_pending_flag_r && !clear_trap_pending_instr_i) |=> trap_pending_flag_r;
    endproperty
    a_trap_hold: assert property (p_trap_hold) else $error("trap flag lost");

    property p_inhibit;
        @(posedge ref_clk_i) disable iff (rst_i)
        trap_pending_flag_r |=> !irq_take_o;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("irq taken under trap");

    property p_vec_trap;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && vector_select_instr_i && trap_pending_flag_r)
            |=> vector_low_o == twi_pkg::VEC_TRAP;
    endproperty
    a_vec_trap: assert property (p_vec_trap) else $error("bad trap vector");

    property p_push;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && trap_event) |=> trap_push_addr_o == $past(ir_pc_i);
    endproperty
    a_push: assert property (p_push) else $error("bad push address");

    property p_boot;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && boot_rom_exec_i) |=> !irq_take_o;
    endproperty
    a_boot: assert property (p_boot) else $error("irq in boot rom");

    property p_edge;
        @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && edge_hit[0]) |=> wake_pin_pending_reg_r[0];
    endproperty
    a_edge: assert property (p_edge) else $error("edge not latched");

    property p_req;
        @(posedge ref_clk_i) disable iff (rst_i)
        irq_take_o |-> $past(global_irq_enable_r && wake_port_group_enable_r);
    endproperty
    a_req: assert property (p_req) else $error("wake req ungated");

endmodule : twi_irq_ctrl

/* File: tb/twi_core_model.sv */
`timescale 1ns/1ps

// ==========================================
// Core side: instruction register, strobes, stack
module twi_core_model (
    input  wire logic  ref_clk_i,
    output logic       ir_load_o,
    output logic [7:0] ir_opcode_o,
    output logic [14:0] ir_pc_o,
    output logic [2:0] cmd_o,
    output logic       pop_o,
    output logic [7:0] sp_o
);
    initial begin
        {ir_load_o, ir_opcode_o, ir_pc_o, cmd_o, pop_o, sp_o} = {1'b0, 8'hff, 27'h0};
    end

    // Opcode lines are scrambled once the load strobe drops
    task automatic fetch(input logic [7:0] opc, input logic [14:0] pc);
        @(posedge ref_clk_i);
        ir_load_o   <= 1'b1;
        ir_opcode_o <= opc;
        ir_pc_o     <= pc;
        @(posedge ref_clk_i);
        ir_load_o   <= 1'b0;
        ir_opcode_o <= ~opc;
    endtask : fetch

    // Bit 0 clear pending, bit 1 vector select, bit 2 return
    task automatic pulse(input logic [2:0] m);
        @(posedge ref_clk_i);
        cmd_o <= m;
        @(posedge ref_clk_i);
        cmd_o <= 3'h0;
    endtask : pulse

    task automatic pop(input logic [7:0] sp);
        @(posedge ref_clk_i);
        pop_o <= 1'b1;
        sp_o  <= sp;
        @(posedge ref_clk_i);
        pop_o <= 1'b0;
        sp_o  <= ~sp;
    endtask : pop
endmodule : twi_core_model

/* File: tb/twi_irq_ctrl_tb.sv */
`timescale 1ns/1ps

module twi_irq_ctrl_tb;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd;
    logic        ir_load_i, pop_w, boot_rom_exec_i = 1'b0;
    logic [7:0]  ir_opcode_i, stack_ptr_i, vector_low_o, wake_pin_i = 8'h02;
    logic [14:0] ir_pc_i, trap_push_addr_o, pc_overpop_val_o;
    logic [2:0]  cmd;
    logic        trap_take_o, pc_overpop_o, wake_irq_o, irq_take_o;
    logic        ce_i = 1'b1, halt_idle_i = 1'b0, wake_resume_o, in_service_o;
    int          n_fail = 0, total_checks = 0, n_take = 0;

    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (irq_take_o === 1'b1) n_take <= n_take + 1;

    twi_core_model i_core (
        .ref_clk_i(ref_clk_i), .ir_load_o(ir_load_i), .ir_opcode_o(ir_opcode_i),
        .ir_pc_o(ir_pc_i), .cmd_o(cmd), .pop_o(pop_w), .sp_o(stack_ptr_i)
    );
    twi_irq_ctrl #(.PINS(8)) i_dut (
        .ref_clk_i, .rst_i, .ce_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ir_load_i, .ir_opcode_i,
        .ir_pc_i, .clear_trap_pending_instr_i(cmd[0]), .vector_select_instr_i(cmd[1]),
        .return_from_irq_instr_i(cmd[2]), .stack_pop_i(pop_w), .stack_ptr_i, .boot_rom_exec_i,
        .halt_idle_i, .wake_pin_i, .trap_take_o, .trap_push_addr_o, .pc_overpop_o,
        .pc_overpop_val_o, .wake_irq_o, .irq_take_o, .wake_resume_o, .vector_low_o,
        .in_service_o
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge ref_clk_i);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!tb) begin
            @(negedge ref_clk_i);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge ref_clk_i);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
        end
        chk(32'(rs), 32'(er));
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
        logic ta, tv;
        tv = 1'b0;
        @(posedge ref_clk_i);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!tv) begin
            @(negedge ref_clk_i);
            ta = s_axi_arvalid && s_axi_arready;
            tv = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge ref_clk_i);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tv) s_axi_rready <= 1'b0;
        end
        chk(rd & m, e);
        chk(32'(rs), 32'(er));
    endtask : rd_chk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_fail++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd_chk(twi_pkg::ADDR_STATUS, 32'hffffffff, 32'h0, 2'h0);
        rd_chk(8'h14, 32'hffffffff, 32'h0, twi_pkg::RESP_SLVERR);
        chk(32'(vector_low_o), 32'he0);
        $display("test reset done");
        wr(twi_pkg::ADDR_CTRL, 32'h1, 2'h0);
        i_core.fetch(8'h5a, 15'h0100);
        tick(0);
        chk(32'(trap_take_o), 32'h0);
        i_core.fetch(twi_pkg::OPC_TRAP, 15'h1234);
        tick(0);
        chk(32'(trap_take_o), 32'h1);
        chk(32'(trap_push_addr_o), 32'h1234);
        chk(32'(in_service_o), 32'h1);
        rd_chk(twi_pkg::ADDR_STATUS, 32'h1, 32'h0, 2'h0);
        rd_chk(twi_pkg::ADDR_CTRL, 32'h3, 32'h1, 2'h0);
        wr(twi_pkg::ADDR_STATUS, 32'h0, twi_pkg::RESP_SLVERR);
        rd_chk(twi_pkg::ADDR_STATUS, 32'h5, 32'h4, 2'h0);
        wr(twi_pkg::ADDR_WAKE_EN, 32'h3, 2'h0);
        wr(twi_pkg::ADDR_WAKE_EDGE, 32'h2, 2'h0);
        wr(twi_pkg::ADDR_CTRL, 32'h3, 2'h0);
        @(posedge ref_clk_i);
        wake_pin_i <= 8'h01;
        tick(4);
        chk(32'(n_take), 32'h0);
        i_core.pulse(3'b010);
        tick(0);
        chk(32'(vector_low_o), 32'hfe);
        i_core.pulse(3'b001);
        i_core.pulse(3'b100);
        tick(4);
        rd_chk(twi_pkg::ADDR_STATUS, 32'hd, 32'hc, 2'h0);
        chk(32'(n_take), 32'h1);
        $display("test trap done");
        rd_chk(twi_pkg::ADDR_WAKE_PEND, 32'hff, 32'h3, 2'h0);
        i_core.pulse(3'b010);
        tick(0);
        chk(32'(vector_low_o), 32'he2);
        wr(twi_pkg::ADDR_WAKE_PEND, 32'h3, 2'h0);
        rd_chk(twi_pkg::ADDR_WAKE_PEND, 32'hff, 32'h0, 2'h0);
        i_core.pulse(3'b100);
        wr(twi_pkg::ADDR_CTRL, 32'h1, 2'h0);
        @(posedge ref_clk_i);
        wake_pin_i <= 8'h02;
        tick(3);
        rd_chk(twi_pkg::ADDR_WAKE_PEND, 32'hff, 32'h0, 2'h0);
        @(posedge ref_clk_i);
        wake_pin_i <= 8'h00;
        tick(3);
        rd_chk(twi_pkg::ADDR_WAKE_PEND, 32'hff, 32'h2, 2'h0);
        chk(32'(wake_irq_o), 32'h0);
        wr(twi_pkg::ADDR_WAKE_EN, 32'h1, 2'h0);
        wr(twi_pkg::ADDR_CTRL, 32'h3, 2'h0);
        tick(1);
        chk(32'(wake_irq_o), 32'h0);
        @(posedge ref_clk_i);
        boot_rom_exec_i <= 1'b1;
        wr(twi_pkg::ADDR_WAKE_EN, 32'h3, 2'h0);
        @(posedge ref_clk_i);
        wake_pin_i <= 8'h02;
        @(posedge ref_clk_i);
        wake_pin_i <= 8'h00;
        tick(4);
        chk(32'(wake_irq_o), 32'h1);
        chk(32'(n_take), 32'h1);
        @(posedge ref_clk_i);
        boot_rom_exec_i <= 1'b0;
        tick(4);
        chk(32'(n_take), 32'h2);
        $display("test wake done");
        wr(twi_pkg::ADDR_WAKE_PEND, 32'h3, 2'h0);
        i_core.pulse(3'b100);
        wr(twi_pkg::ADDR_CTRL, 32'h1, 2'h0);
        @(posedge ref_clk_i);
        halt_idle_i <= 1'b1;
        wake_pin_i  <= 8'h01;
        tick(1);
        chk(32'(wake_resume_o), 32'h1);
        wr(twi_pkg::ADDR_WAKE_PEND, 32'h1, 2'h0);
        wr(twi_pkg::ADDR_CTRL, 32'h3, 2'h0);
        @(posedge ref_clk_i);
        wake_pin_i <= 8'h03;
        @(posedge ref_clk_i);
        wake_pin_i <= 8'h01;
        tick(1);
        chk(32'(wake_resume_o), 32'h0);
        chk(32'(n_take), 32'h2);
        @(posedge ref_clk_i);
        halt_idle_i <= 1'b0;
        tick(4);
        chk(32'(n_take), 32'h3);
        chk(32'(in_service_o), 32'h1);
        $display("test halt done");
        @(posedge ref_clk_i);
        ce_i <= 1'b0;
        i_core.pop(8'h70);
        tick(0);
        chk(32'(pc_overpop_o), 32'h0);
        @(posedge ref_clk_i);
        ce_i <= 1'b1;
        i_core.pop(8'h70);
        tick(0);
        chk(32'(pc_overpop_o), 32'h1);
        chk(32'(pc_overpop_val_o), 32'h7fff);
        i_core.pop(8'h6f);
        tick(0);
        chk(32'(pc_overpop_o), 32'h0);
        $display("test overpop done");
        i_core.fetch(twi_pkg::OPC_TRAP, 15'h0042);
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        i_core.pulse(3'b010);
        tick(0);
        chk(32'(vector_low_o), 32'he0);
        chk(32'(trap_take_o), 32'h0);
        $display("test rearm done");
        print_verdict();
    end
endmodule : twi_irq_ctrl_tb
